// file: inc/sfr_pkg.sv
// Package for the serial frame receiver: constants, codes and state types.
// Assumes an 8-bit character, LSB-first bit stream and a host that owns the
// configuration ports.
package sfr_pkg;
  localparam logic [7:0] SFR_FLAG_DEFAULT = 8'h7e;
  localparam logic [7:0] SFR_BROADCAST_ADDR = 8'hff;
  localparam logic [15:0] SFR_CRC_PRESET = 16'hffff;
  localparam logic [15:0] SFR_CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] SFR_CRC_GOOD = 16'h1d0f;
  localparam int SFR_ABORT_ONES = 7;
  localparam logic [2:0] SFR_ONES_ABORT = 3'h7;
  localparam logic [2:0] SFR_ONES_STUFF = 3'h5;
  localparam logic [2:0] SFR_BIT_LAST = 3'h7;
  localparam logic [2:0] SFR_RESIDUE_ZERO = 3'h0;
  localparam logic [2:0] SFR_CMD_NULL = 3'h0;
  localparam logic [2:0] SFR_CMD_RESET_EXT = 3'h2;
  localparam logic [2:0] SFR_CMD_ENABLE_NEXT = 3'h4;
  localparam logic [2:0] SFR_CMD_ERROR_RESET = 3'h6;
  localparam logic [2:0] SFR_CMD_HUNT = 3'h7;

  typedef enum logic [3:0] {
    SFR_HUNT = 4'h1,
    SFR_ADDR = 4'h2,
    SFR_DATA = 4'h4,
    SFR_SKIP = 4'h8
  } sfr_state_t;
endpackage : sfr_pkg

// file: hdl/sfr_bit_sync.sv
// Two-flop level synchroniser for single bits entering the core clock.
// Assumes the input is a level that stays put for at least two core clocks.
`timescale 1ns/100ps
`default_nettype none
module sfr_bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule // sfr_bit_sync
`default_nettype wire

// file: hdl/sfr_event_sync.sv
// Toggle-based pulse crossing from the link clock to the core clock, with an
// 8-bit payload held stable beside the toggle.
// Assumes events are at least three core clocks apart (one per character).
`timescale 1ns/100ps
`default_nettype none
module sfr_event_sync #(
  parameter int WIDTH = 8
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_pulse,
  input wire logic [WIDTH-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_pulse,
  output logic [WIDTH-1:0] dst_data
);
  logic tog_reg;
  logic [WIDTH-1:0] hold_reg;
  logic [2:0] dsync_reg;

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      tog_reg <= 1'b0;
      hold_reg <= '0;
    end else if (src_pulse) begin
      tog_reg <= ~tog_reg;
      hold_reg <= src_data;
    end
  end

  // Payload is read only after the toggle has settled two flops deep
  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      dsync_reg <= '0;
    end else begin
      dsync_reg <= {dsync_reg[1:0], tog_reg};
    end
  end

  assign dst_pulse = dsync_reg[2] != dsync_reg[1];
  assign dst_data = hold_reg;
endmodule // sfr_event_sync
`default_nettype wire

// file: hdl/sfr_frame_rx.sv
// Receive side of one bit-oriented framed serial channel: flag hunt, zero
// deletion, address filter, DMA ready handshake, CRC, residue and abort status.
// Assumes bits arrive LSB first on rx_data, sampled on rising link_clk, and
// that the host drives the configuration ports from core_clk.
//
// Function
// - Opening and closing delimiters are matched against the programmed flag pattern.
// - In address search, first byte after flag must match station or broadcast.
// - Broadcast address is the fixed all-ones byte.
// - Station address input is the compared secondary address.
// - No receive interrupt until opening flag and matching address seen.
// - First-character mode interrupts on address byte; later bytes go to DMA.
// - During DMA, carrier detect change or abort raises external status interrupt.
// - Receive overrun raises special receive condition interrupt; here only when first_char_int_en is set.
// - Closing flag raises interrupt and drops wait/ready; here the interrupt needs first_char_int_en set.
// - Residue code reports bit split of final two bytes at end of frame.
// - With CRC enabled, remainder other than 0x1d0f sets CRC error.
// - Seven or more consecutive ones set break/abort status.
// - End of continuous ones clears break/abort and raises another interrupt.
// - Second abort interrupt only after host resets external status.
// - Status-affects-vector acts only through channel B setting.
`timescale 1ns/100ps
`default_nettype none
module sfr_frame_rx
  import sfr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic rx_data,
  input wire logic carrier_detect_input,
  input wire logic rx_enable,
  input wire logic addr_search_en,
  input wire logic crc_enable,
  input wire logic first_char_int_en,
  input wire logic ext_int_en,
  input wire logic wait_ready_en,
  input wire logic status_vector_chb,
  input wire logic [7:0] station_address,
  input wire logic [7:0] flag_pattern,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic host_read,
  output logic [7:0] rx_byte,
  output logic ready,
  output logic rx_int,
  output logic ext_int,
  output logic special_int,
  output logic status_vector_mod,
  output logic break_abort,
  output logic carrier_status,
  output logic end_of_frame,
  output logic crc_error,
  output logic overrun,
  output logic [2:0] residue
);
  // ---- Link domain ----
  logic [1:0] rxs_reg;
  logic [1:0] cfg_reg;
  logic [7:0] shift_reg;
  logic [7:0] byte_reg;
  logic [2:0] ones_reg;
  logic [2:0] bitcnt_reg;
  logic [15:0] crc_reg;
  logic in_frame_reg;
  logic abort_l_reg;
  logic byte_pulse_reg;
  logic eof_pulse_reg;
  logic [7:0] eof_info_reg;
  logic bit_in;
  logic link_en;
  logic flag_hit;
  logic stuffed;
  logic [7:0] shift_next;
  logic [15:0] crc_next;
  logic crc_fb;
  // Data is taken eight bits late so a closing flag never enters CRC or bytes
  localparam logic [3:0] FLAG_BITS = 4'h8;
  logic [7:0] asm_reg;
  logic [2:0] ones_d_reg;
  logic [3:0] skip_reg;
  logic [1:0] eof_dly_reg;
  logic drop_bit;
  logic take_bit;
  logic byte_done;
  logic eof_now;
  logic [15:0] crc_cur;
  logic [15:0] crc_rev;
  logic [2:0] cnt_cur;

  // Pin input passes two link flops; enable crosses as a level
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      rxs_reg <= 2'b11;
      cfg_reg <= 2'b00;
    end else begin
      rxs_reg <= {rxs_reg[0], rx_data};
      cfg_reg <= {cfg_reg[0], rx_enable};
    end
  end
  assign bit_in = rxs_reg[1];
  assign link_en = cfg_reg[1];
  assign shift_next = {bit_in, shift_reg[7:1]};
  assign flag_hit = shift_next == flag_pattern;
  assign drop_bit = shift_reg[0];
  assign stuffed = ones_d_reg == SFR_ONES_STUFF && !drop_bit;
  assign take_bit = in_frame_reg && skip_reg == 4'h0 && !stuffed;
  assign byte_done = take_bit && bitcnt_reg == SFR_BIT_LAST;
  assign crc_fb = crc_reg[0] ^ drop_bit;
  assign crc_next = crc_fb ? ((crc_reg >> 1) ^ SFR_CRC_POLY_REV) : (crc_reg >> 1);
  assign crc_cur = take_bit ? crc_next : crc_reg;
  assign cnt_cur = take_bit ? bitcnt_reg + 3'h1 : bitcnt_reg;
  assign eof_now = link_en && flag_hit && in_frame_reg && (cnt_cur != 3'h0 || crc_cur != SFR_CRC_PRESET);
  // Register shifts right, so the remainder reads bit-reversed
  genvar gi;
  generate
    for (gi = 0; gi < $bits(crc_cur); gi++) begin : g_crc_rev
      assign crc_rev[gi] = crc_cur[$bits(crc_cur) - 1 - gi];
    end
  endgenerate

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= 8'h00;
      byte_reg <= 8'h00;
      ones_reg <= 3'h0;
      bitcnt_reg <= 3'h0;
      crc_reg <= SFR_CRC_PRESET;
      in_frame_reg <= 1'b0;
      abort_l_reg <= 1'b0;
      byte_pulse_reg <= 1'b0;
      eof_pulse_reg <= 1'b0;
      eof_info_reg <= 8'h00;
      asm_reg <= 8'h00;
      ones_d_reg <= 3'h0;
      skip_reg <= 4'h0;
      eof_dly_reg <= 2'b00;
    end else begin
      byte_pulse_reg <= byte_done;
      // End of frame trails the last byte so DMA can still fetch it
      eof_dly_reg <= {eof_dly_reg[0], eof_now};
      eof_pulse_reg <= eof_dly_reg[1];
      shift_reg <= shift_next;
      if (drop_bit && ones_d_reg != SFR_ONES_ABORT) begin
        ones_d_reg <= ones_d_reg + 3'h1;
      end else if (!drop_bit) begin
        ones_d_reg <= 3'h0;
      end
      if (skip_reg != 4'h0) begin
        skip_reg <= skip_reg - 4'h1;
      end
      if (byte_done) begin
        byte_reg <= {drop_bit, asm_reg[7:1]};
      end
      if (bit_in && ones_reg != SFR_ONES_ABORT) begin
        ones_reg <= ones_reg + 3'h1;
      end else if (!bit_in) begin
        ones_reg <= 3'h0;
      end
      if (bit_in && ones_reg >= SFR_ONES_ABORT - 3'h1) begin
        abort_l_reg <= 1'b1;
        in_frame_reg <= 1'b0;
      end else if (!bit_in) begin
        abort_l_reg <= 1'b0;
      end
      if (!link_en) begin
        in_frame_reg <= 1'b0;
      end else if (flag_hit) begin
        // closing check of remainder; residue from partial bits
        if (eof_now) begin
          eof_info_reg <= {4'h0, crc_enable && crc_rev != SFR_CRC_GOOD, cnt_cur};
        end
        in_frame_reg <= 1'b1;
        bitcnt_reg <= 3'h0;
        crc_reg <= SFR_CRC_PRESET;
        skip_reg <= FLAG_BITS;
      end else if (take_bit) begin
        crc_reg <= crc_next;
        bitcnt_reg <= bitcnt_reg + 3'h1;
        asm_reg <= {drop_bit, asm_reg[7:1]};
      end
    end
  end

  // ---- Crossings ----
  logic byte_evt;
  logic eof_evt;
  logic [7:0] byte_data;
  logic [7:0] eof_data;
  logic [1:0] lvl_sync;

  sfr_event_sync #(.WIDTH(8)) u_byte_sync (
    .src_clk(link_clk), .src_rst(rst), .src_pulse(byte_pulse_reg), .src_data(byte_reg),
    .dst_clk(core_clk), .dst_rst(rst), .dst_pulse(byte_evt), .dst_data(byte_data)
  );
  sfr_event_sync #(.WIDTH(8)) u_eof_sync (
    .src_clk(link_clk), .src_rst(rst), .src_pulse(eof_pulse_reg), .src_data(eof_info_reg),
    .dst_clk(core_clk), .dst_rst(rst), .dst_pulse(eof_evt), .dst_data(eof_data)
  );
  sfr_bit_sync #(.WIDTH(2)) u_lvl_sync (
    .clk(core_clk), .rst(rst), .din({abort_l_reg, carrier_detect_input}), .dout(lvl_sync)
  );

  // ---- Core domain ----
  sfr_state_t state_reg;
  sfr_state_t state_next;
  logic [7:0] rx_byte_reg;
  logic full_reg;
  logic rx_int_reg;
  logic arm_reg;
  logic ext_latch_reg;
  logic ext_pend_reg;
  logic [1:0] ext_snap_reg;
  logic eof_reg;
  logic crc_err_reg;
  logic ovr_reg;
  logic [2:0] residue_reg;
  logic addr_match;
  logic addr_ok;
  logic take_data;
  logic cmd_ext_rst;
  logic cmd_err_rst;
  logic cmd_arm;
  logic cmd_hunt;
  logic [1:0] lvl_now;
  logic ext_change;

  // match on station or broadcast; fixed all ones; station
  assign addr_match = byte_data == station_address || byte_data == SFR_BROADCAST_ADDR;
  assign addr_ok = !addr_search_en || addr_match;
  assign take_data = byte_evt && state_reg == SFR_DATA;
  assign cmd_ext_rst = cmd_valid && cmd_code == SFR_CMD_RESET_EXT;
  assign cmd_err_rst = cmd_valid && cmd_code == SFR_CMD_ERROR_RESET;
  assign cmd_arm = cmd_valid && cmd_code == SFR_CMD_ENABLE_NEXT;
  assign cmd_hunt = cmd_valid && cmd_code == SFR_CMD_HUNT;
  assign lvl_now = lvl_sync;
  assign ext_change = lvl_now != ext_snap_reg;

  // hunt for flag then address before any receive interrupt
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SFR_HUNT: if (byte_evt) state_next = addr_ok ? SFR_DATA : SFR_SKIP;
      SFR_DATA, SFR_SKIP: if (eof_evt || cmd_hunt) state_next = SFR_HUNT;
      default: state_next = SFR_HUNT;
    endcase
    if (!rx_enable || lvl_now[1]) state_next = SFR_HUNT;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SFR_HUNT;
      rx_byte_reg <= 8'h00;
      full_reg <= 1'b0;
      rx_int_reg <= 1'b0;
      arm_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      // address byte interrupts once; later bytes feed DMA
      if (state_reg == SFR_HUNT && byte_evt && addr_ok && rx_enable) begin
        rx_byte_reg <= byte_data;
        full_reg <= 1'b1;
        if (first_char_int_en && arm_reg) begin
          rx_int_reg <= 1'b1;
          arm_reg <= 1'b0;
        end
      end else if (take_data) begin
        rx_byte_reg <= byte_data;
        full_reg <= 1'b1;
      end else if (host_read) begin
        full_reg <= 1'b0;
        rx_int_reg <= 1'b0;
      end
      if (cmd_arm) begin
        arm_reg <= 1'b1;
      end
    end
  end

  // External status latch: snapshot frozen until host resets it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_latch_reg <= 1'b0;
      ext_pend_reg <= 1'b0;
      ext_snap_reg <= 2'b00;
    end else begin
      // second abort event waits for reset command; on release
      if (!ext_latch_reg && ext_change) begin
        // carrier or abort change raises external status
        ext_latch_reg <= 1'b1;
        ext_pend_reg <= 1'b1;
        ext_snap_reg <= lvl_now;
      end else if (cmd_ext_rst) begin
        ext_latch_reg <= 1'b0;
        ext_pend_reg <= 1'b0;
        ext_snap_reg <= ext_snap_reg;
      end
    end
  end

  // Special conditions; a new event wins over error reset in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eof_reg <= 1'b0;
      crc_err_reg <= 1'b0;
      ovr_reg <= 1'b0;
      residue_reg <= SFR_RESIDUE_ZERO;
    end else begin
      // closing flag flags end of frame; residue, CRC
      if (eof_evt && state_reg == SFR_DATA) begin
        eof_reg <= 1'b1;
        crc_err_reg <= eof_data[3];
        residue_reg <= eof_data[2:0];
      end else if (cmd_err_rst) begin
        // error reset clears the latched condition
        eof_reg <= 1'b0;
        crc_err_reg <= 1'b0;
      end
      // overrun when a byte lands on an unread one
      if (take_data && full_reg && !host_read) begin
        ovr_reg <= 1'b1;
      end else if (cmd_err_rst) begin
        ovr_reg <= 1'b0;
      end
    end
  end

  assign rx_byte = rx_byte_reg;
  // ready while byte waits; DMA read clears it; drop at end
  assign ready = wait_ready_en && full_reg && state_reg == SFR_DATA && !eof_reg;
  assign rx_int = rx_int_reg;
  assign ext_int = ext_int_en && ext_pend_reg;
  assign special_int = (first_char_int_en) && (eof_reg || ovr_reg);
  // vector modification only from the channel B setting
  assign status_vector_mod = status_vector_chb && (special_int || ext_int || rx_int);
  // status reflects latched abort; clears on release after reset
  assign break_abort = ext_snap_reg[1];
  assign carrier_status = ext_snap_reg[0];
  assign end_of_frame = eof_reg;
  assign crc_error = crc_err_reg;
  assign overrun = ovr_reg;
  assign residue = residue_reg;

  a_overrun_sets: assert property (@(posedge core_clk) disable iff (rst)
    take_data && full_reg && !host_read |=> overrun) else $error("overrun not set");
  a_ready_cond: assert property (@(posedge core_clk) disable iff (rst)
    ready |-> wait_ready_en && full_reg) else $error("ready without byte");
  a_eof_drops_ready: assert property (@(posedge core_clk) disable iff (rst)
    eof_evt && state_reg == SFR_DATA |=> !ready && end_of_frame) else $error("ready after eof");
  a_ext_hold: assert property (@(posedge core_clk) disable iff (rst)
    ext_pend_reg && !cmd_ext_rst |=> ext_pend_reg) else $error("ext dropped");
  a_no_int_hunt: assert property (@(posedge core_clk) disable iff (rst)
    $rose(rx_int) |-> $past(state_reg) == SFR_HUNT) else $error("int outside hunt");
  a_addr_filter: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == SFR_HUNT && byte_evt && addr_search_en && !addr_match && rx_enable
    |=> state_reg != SFR_DATA) else $error("bad address accepted");
  a_err_clear: assert property (@(posedge core_clk) disable iff (rst)
    cmd_err_rst && !eof_evt && !take_data |=> !overrun && !end_of_frame) else $error("error reset");
  a_vector_chb: assert property (@(posedge core_clk) disable iff (rst)
    status_vector_mod |-> status_vector_chb) else $error("vector without chb");
endmodule // sfr_frame_rx
`default_nettype wire

// file: verif/sfr_link_src.sv
// Far-end serial transmitter: flag fill, zero stuffing, FCS and abort runs.
// Assumes the bench runs link_clk and calls the put_ tasks in zero time.
`timescale 1ns/100ps
`default_nettype none
module sfr_link_src
  import sfr_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst,
  output logic rx_data
);
  bit q[$];
  logic [15:0] crc;
  int ones;
  int fidx;
  task automatic put_bit(input bit b, input bit stuff);
    q.push_back(b);
    if (stuff) begin
      ones = b ? ones + 1 : 0;
      if (ones == 5) begin
        q.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic put_flag();
    for (int i = 0; i < 8; i++) q.push_back(SFR_FLAG_DEFAULT[i]);
    ones = 0;
    crc = SFR_CRC_PRESET;
  endtask
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      crc = (crc >> 1) ^ ((crc[0] ^ b[i]) ? SFR_CRC_POLY_REV : 16'h0000);
      put_bit(b[i], 1'b1);
    end
  endtask
  task automatic put_fcs(input bit bad);
    logic [15:0] f;
    f = ~crc ^ {15'h0000, bad};
    for (int i = 0; i < 16; i++) put_bit(f[i], 1'b1);
  endtask
  task automatic put_ones(input int n);
    repeat (n) q.push_back(1'b1);
    ones = 0;
  endtask
  // Queued bits start only on a flag boundary, so fill never forms an abort
  always @(negedge link_clk or posedge rst) begin
    if (rst) begin
      rx_data <= 1'b0;
      fidx <= 0;
    end else if (fidx == 0 && q.size() > 0) begin
      rx_data <= q.pop_front();
    end else begin
      rx_data <= SFR_FLAG_DEFAULT[fidx[2:0]];
      fidx <= (fidx + 1) % 8;
    end
  end
endmodule // sfr_link_src
`default_nettype wire

// file: verif/testbench.sv
// Bench for the frame receiver: plays host and DMA, checks ports.
// Assumes sfr_link_src drives rx_data as the far-end transmitter.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sfr_pkg::*;
  ;
  localparam logic [7:0] STA = 8'h35;
  logic core_clk = 0, link_clk = 0, rst = 1, rx_data;
  logic carrier_detect_input = 0, rx_enable = 0, addr_search_en = 1, crc_enable = 1, first_char_int_en = 1;
  logic ext_int_en = 1, wait_ready_en = 0, status_vector_chb = 0, cmd_valid = 0, host_read = 0;
  logic [7:0] station_address = STA, flag_pattern = SFR_FLAG_DEFAULT;
  logic [2:0] cmd_code = SFR_CMD_NULL;
  logic [7:0] rx_byte;
  logic [2:0] residue;
  logic ready, rx_int, ext_int, special_int, status_vector_mod, break_abort, carrier_status;
  logic end_of_frame, crc_error, overrun;
  logic [7:0] payload [3] = '{8'h7e, 8'hff, 8'h3c};
  int n_fail = 0, samples_checked = 0;
  always #2 core_clk = ~core_clk;
  always #7.5 link_clk = ~link_clk;
  sfr_frame_rx DUT (.*);
  sfr_link_src far_end (.link_clk(link_clk), .rst(rst), .rx_data(rx_data));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cmd(input logic [2:0] c);
    @(negedge core_clk);
    cmd_valid = 1;
    cmd_code = c;
    @(negedge core_clk);
    cmd_valid = 0;
    cmd_code = SFR_CMD_NULL;
  endtask
  task automatic hread();
    @(negedge core_clk);
    host_read = 1;
    @(negedge core_clk);
    host_read = 0;
  endtask
  task automatic send_frame(input logic [7:0] a, input bit bad);
    far_end.put_flag();
    far_end.put_byte(a);
    for (int i = 0; i < 3; i++) far_end.put_byte(payload[i]);
    far_end.put_fcs(bad);
    far_end.put_flag();
  endtask
  // Address by interrupt, rest by ready; drain=0 leaves bytes unread
  task automatic take_frame(input logic [7:0] a, input bit drain);
    for (int i = 0; i < 600 && rx_int !== 1'b1; i++) @(negedge core_clk);
    chkb(rx_int, 1'b1);
    chk(rx_byte, a);
    chkb(ready, 1'b0);
    hread();
    chkb(rx_int, 1'b0);
    wait_ready_en = 1;
    for (int k = 0; k < 5 && drain; k++) begin
      for (int i = 0; i < 200 && ready !== 1'b1; i++) @(negedge core_clk);
      chkb(ready, 1'b1);
      if (k < 3) chk(rx_byte, payload[k]);
      hread();
      chkb(ready, 1'b0);
    end
    for (int i = 0; i < 600 && end_of_frame !== 1'b1; i++) @(negedge core_clk);
    chkb(end_of_frame, 1'b1);
    chkb(special_int, 1'b1);
    chkb(status_vector_mod, 1'b0);
    chk({5'h00, residue}, 8'h00);
    if (drain) chkb(ready, 1'b0);
    else begin
      chkb(overrun, 1'b1);
      hread();
    end
    wait_ready_en = 0;
  endtask
  task automatic clear_status();
    cmd(SFR_CMD_ERROR_RESET);
    chk({4'h0, end_of_frame, crc_error, overrun, special_int}, 8'h00);
  endtask
  task automatic t_reset();
    chk({rx_int, ready, ext_int, special_int, break_abort, end_of_frame, crc_error, overrun}, 8'h00);
    chk(rx_byte, 8'h00);
  endtask
  task automatic t_station();
    cmd(SFR_CMD_ENABLE_NEXT);
    send_frame(STA, 1'b0);
    take_frame(STA, 1'b1);
    chkb(crc_error, 1'b0);
    clear_status();
  endtask
  task automatic t_broadcast();
    cmd(SFR_CMD_ENABLE_NEXT);
    send_frame(SFR_BROADCAST_ADDR, 1'b1);
    take_frame(SFR_BROADCAST_ADDR, 1'b1);
    chkb(crc_error, 1'b1);
    status_vector_chb = 1;
    @(negedge core_clk);
    chkb(status_vector_mod, 1'b1);
    status_vector_chb = 0;
    clear_status();
  endtask
  task automatic t_foreign();
    logic seen;
    seen = 1'b0;
    cmd(SFR_CMD_ENABLE_NEXT);
    wait_ready_en = 1;
    send_frame(8'h5a, 1'b0);
    repeat (400) begin
      @(negedge core_clk);
      seen = seen | rx_int | ready | end_of_frame;
    end
    chkb(seen, 1'b0);
    wait_ready_en = 0;
  endtask
  task automatic t_overrun();
    cmd(SFR_CMD_ENABLE_NEXT);
    send_frame(STA, 1'b0);
    take_frame(STA, 1'b0);
    clear_status();
  endtask
  task automatic t_carrier();
    for (int k = 1; k >= 0; k--) begin
      carrier_detect_input = k[0];
      for (int i = 0; i < 50 && ext_int !== 1'b1; i++) @(negedge core_clk);
      chkb(ext_int, 1'b1);
      chkb(carrier_status, k[0]);
      cmd(SFR_CMD_RESET_EXT);
      chkb(ext_int, 1'b0);
    end
  endtask
  task automatic t_abort();
    cmd(SFR_CMD_ENABLE_NEXT);
    far_end.put_flag();
    far_end.put_byte(STA);
    far_end.put_ones(40);
    for (int i = 0; i < 400 && break_abort !== 1'b1; i++) @(negedge core_clk);
    chkb(ext_int, 1'b1);
    cmd(SFR_CMD_RESET_EXT);
    chkb(ext_int, 1'b0);
    chkb(break_abort, 1'b1);
    for (int i = 0; i < 400 && break_abort !== 1'b0; i++) @(negedge core_clk);
    chkb(ext_int, 1'b1);
    cmd(SFR_CMD_RESET_EXT);
    chkb(ext_int, 1'b0);
    hread();
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 0;
    t_reset();
    rx_enable = 1;
    cmd(SFR_CMD_RESET_EXT);
    repeat (100) @(negedge core_clk);
    t_station();
    t_broadcast();
    t_foreign();
    t_overrun();
    t_carrier();
    t_abort();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
